// [core/pin_irq_defines.vh]
/*
 * constants for the pin interrupt and pattern match engine.
 * assumes inclusion by bare name from the core design file.
 */
`ifndef PIN_IRQ_DEFINES_VH
`define PIN_IRQ_DEFINES_VH

// channel and pin counts
`define NUM_CHAN 8
`define PIN_COUNT 32
`define PIN_SEL_W 5
`define SLICE_SRC_W 3
`define SLICE_COND_W 3

// channel mode field values
`define MODE_EDGE 1'b0
`define MODE_LEVEL 1'b1

// slice condition codes
`define COND_ALWAYS 3'h0
`define COND_RISE_STICKY 3'h1
`define COND_FALL_STICKY 3'h2
`define COND_ANY_STICKY 3'h3
`define COND_HIGH 3'h4
`define COND_LOW 3'h5
`define COND_NEVER 3'h6
`define COND_ANY_EDGE 3'h7

// reset values
`define RST_FLAGS 8'h00
`define RST_IRQ 8'h00
`define RST_BIT 1'b0

`endif

// [core/pin_irq_pattern_match.v]
/*
 * pin interrupt and pattern match engine: eight selectable pin channels,
 * each an edge or level interrupt, or a sum-of-products pattern matcher
 * over the same channels.
 * assumes pins are asynchronous to clk; all configuration ports are held
 * by system configuration logic on clk; clear strobes are one-cycle pulses
 * from the single-cycle i/o bus logic on clk.
 * assumes the interrupt controller samples irq as levels on clk, and that
 * the dma trigger mux and the event input take one-cycle pulses or levels
 * on the same clock; no wider handshake is offered.
 * a pin change reaches irq three edges later in level mode and four in
 * edge mode; software that polls the flags must allow for that lag.
 * pattern mode owns all eight irq lines while pattern_en is high; the
 * edge flags keep recording so that a return to pin mode sees history.
 */
//
// Contract
// - eight channels select any pin, edge/level
// - each channel drives its own irq line
// - edge channel fires on rise, fall, both
// - level channel active high or low
// - pin interrupts raise wake request
// - pin selection independent of pin function
// - controls are single-cycle same-clock ports
// - eight channels feed one sum-of-products
// - each slice tests level or transition
// - each product term raises its irq
// - any match optionally pulses cpu event
// - pattern matches never raise wake request
// - channels zero and one feed dma triggers; code holds both triggers low while pattern_en is high
// - combined match drives dedicated output
`timescale 1ns/1ps
`include "pin_irq_defines.vh"

module pin_irq_pattern_match (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // device pins
   input wire [`PIN_COUNT-1:0] pins,
   // channel pin selection, channel n in bits [5n+4:5n]
   input wire [`NUM_CHAN*`PIN_SEL_W-1:0] pin_sel,
   // channel configuration
   input wire [`NUM_CHAN-1:0] chan_mode,
   input wire [`NUM_CHAN-1:0] rise_en,
   input wire [`NUM_CHAN-1:0] fall_en,
   input wire [`NUM_CHAN-1:0] level_en,
   input wire [`NUM_CHAN-1:0] level_high,
   // sticky edge clears, one-cycle pulses
   input wire [`NUM_CHAN-1:0] clr_rise,
   input wire [`NUM_CHAN-1:0] clr_fall,
   // pattern match configuration
   input wire pattern_en,
   input wire event_en,
   input wire [`NUM_CHAN*`SLICE_SRC_W-1:0] slice_src,
   input wire [`NUM_CHAN*`SLICE_COND_W-1:0] slice_cond,
   input wire [`NUM_CHAN-1:0] term_end,
   input wire pattern_clr_edges,
   // interrupt requests and status
   output reg [`NUM_CHAN-1:0] irq,
   output reg [`NUM_CHAN-1:0] rise_flag,
   output reg [`NUM_CHAN-1:0] fall_flag,
   output reg [`NUM_CHAN-1:0] pin_level,
   output reg wake_req,
   // dma triggers
   output reg pin_irq_zero,
   output reg pin_irq_one,
   // pattern match results
   output reg pattern_match_out,
   output reg cpu_event_notify
);

   function pick_pin;
      input [`PIN_COUNT-1:0] vec;
      input [`PIN_SEL_W-1:0] idx;
      begin
         pick_pin = vec[idx];
      end
   endfunction

   function pick_chan;
      input [`NUM_CHAN-1:0] vec;
      input [`SLICE_SRC_W-1:0] idx;
      begin
         pick_chan = vec[idx];
      end
   endfunction

   // edge toward want_high between the old and the current level
   function edge_seen;
      input now_lvl;
      input old_lvl;
      input want_high;
      begin
         edge_seen = (now_lvl == want_high) & (old_lvl != want_high);
      end
   endfunction

   reg [`NUM_CHAN-1:0] sync1;
   reg [`NUM_CHAN-1:0] sync2;
   reg [`NUM_CHAN-1:0] prev;
   reg [`NUM_CHAN-1:0] slice_rise;
   reg [`NUM_CHAN-1:0] slice_fall;
   reg [`NUM_CHAN-1:0] term_prev;
   wire [`NUM_CHAN-1:0] rise_now;
   wire [`NUM_CHAN-1:0] fall_now;
   wire [`NUM_CHAN-1:0] slice_true;
   wire [`NUM_CHAN-1:0] pin_req;
   reg [`NUM_CHAN-1:0] next_term;
   // registered output sources
   reg [`NUM_CHAN-1:0] next_irq;
   reg [`NUM_CHAN-1:0] next_term_prev;
   reg next_wake;
   reg next_dma_zero;
   reg next_dma_one;
   reg next_match;
   reg next_event;
   reg acc;
   integer k;

   // pin mux ahead of the synchroniser, so any pin function can be
   // watched; a selection change may show one spurious edge
   genvar i;
   generate
      for (i = 0; i < `NUM_CHAN; i = i + 1) begin : g_chan
         // two flops in front of any logic that reads the pin
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               sync1[i] <= 1'b0;
               sync2[i] <= 1'b0;
            end else begin
               sync1[i] <= pick_pin(pins,
                  pin_sel[i*`PIN_SEL_W +: `PIN_SEL_W]);
               sync2[i] <= sync1[i];
            end
         end

         // history of the settled level, read by edge detection only
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               prev[i] <= 1'b0;
            end else begin
               prev[i] <= sync2[i];
            end
         end

         assign rise_now[i] = edge_seen(sync2[i], prev[i], 1'b1);
         assign fall_now[i] = edge_seen(sync2[i], prev[i], 1'b0);

         // edge channel: sticky flags; level channel: follows the pin
         reg req;
         always @* begin
            req = 1'b0;
            if (chan_mode[i] == `MODE_EDGE) begin
               req = (rise_en[i] & rise_flag[i]) |
                  (fall_en[i] & fall_flag[i]);
            end else begin
               // polarity compare on the settled level, no glitch path
               req = level_en[i] & ~(sync2[i] ^ level_high[i]);
            end
         end
         assign pin_req[i] = req;

         // slice source is one of the eight channels
         wire s_lvl;
         wire s_rise;
         wire s_fall;
         wire s_edge;
         reg s_true;
         wire [`SLICE_SRC_W-1:0] src;
         assign src = slice_src[i*`SLICE_SRC_W +: `SLICE_SRC_W];
         assign s_lvl = pick_chan(sync2, src);
         assign s_rise = pick_chan(rise_now, src);
         assign s_fall = pick_chan(fall_now, src);
         assign s_edge = s_rise | s_fall;

         // sticky slice edges; a new edge wins over the bulk clear
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               slice_rise[i] <= 1'b0;
               slice_fall[i] <= 1'b0;
            end else begin
               if (s_rise) begin
                  slice_rise[i] <= 1'b1;
               end else if (pattern_clr_edges) begin
                  slice_rise[i] <= 1'b0;
               end
               if (s_fall) begin
                  slice_fall[i] <= 1'b1;
               end else if (pattern_clr_edges) begin
                  slice_fall[i] <= 1'b0;
               end
            end
         end

         always @* begin
            case (slice_cond[i*`SLICE_COND_W +: `SLICE_COND_W])
               `COND_ALWAYS: s_true = 1'b1;
               `COND_RISE_STICKY: s_true = slice_rise[i] | s_rise;
               `COND_FALL_STICKY: s_true = slice_fall[i] | s_fall;
               `COND_ANY_STICKY: s_true = slice_rise[i] | slice_fall[i] |
                  s_edge;
               `COND_HIGH: s_true = s_lvl;
               `COND_LOW: s_true = ~s_lvl;
               `COND_NEVER: s_true = 1'b0;
               `COND_ANY_EDGE: s_true = s_edge;
               default: s_true = 1'b0;
            endcase
         end
         assign slice_true[i] = s_true;
      end
   endgenerate

   // product terms close at marked slices; an unclosed tail is ignored
   // so a spare slice can be parked without a term of its own; a term is
   // the and of its slices, the sum is taken at the output stage
   always @* begin
      acc = 1'b1;
      next_term = 8'h00;
      for (k = 0; k < `NUM_CHAN; k = k + 1) begin
         acc = acc & slice_true[k];
         if (term_end[k]) begin
            next_term[k] = acc;
            acc = 1'b1;
         end
      end
   end

   // edge status flags; a new edge wins over a clear in the same cycle
   generate
      for (i = 0; i < `NUM_CHAN; i = i + 1) begin : g_flag
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               rise_flag[i] <= `RST_BIT;
               fall_flag[i] <= `RST_BIT;
               pin_level[i] <= `RST_BIT;
            end else begin
               // clears come from same-clock bus logic, no synchroniser
               if (rise_now[i]) begin
                  rise_flag[i] <= 1'b1;
               end else if (clr_rise[i]) begin
                  rise_flag[i] <= 1'b0;
               end
               if (fall_now[i]) begin
                  fall_flag[i] <= 1'b1;
               end else if (clr_fall[i]) begin
                  fall_flag[i] <= 1'b0;
               end
               pin_level[i] <= sync2[i];
            end
         end
      end
   endgenerate

   // next output values; pattern mode takes over the interrupt lines
   always @* begin
      next_irq = pin_req;
      next_wake = |pin_req;
      next_dma_zero = pin_req[0];
      next_dma_one = pin_req[1];
      next_match = 1'b0;
      next_event = 1'b0;
      next_term_prev = 8'h00;
      if (pattern_en) begin
         next_irq = next_term;
         // pattern results never wake the chip
         next_wake = 1'b0;
         next_dma_zero = 1'b0;
         next_dma_one = 1'b0;
         next_match = |next_term;
         // only a term that was false last cycle counts as a new match
         next_event = event_en & (|(next_term & ~term_prev));
         next_term_prev = next_term;
      end
   end

   // every output leaves straight from a flip-flop
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= `RST_IRQ;
         term_prev <= `RST_IRQ;
         wake_req <= 1'b0;
         pin_irq_zero <= 1'b0;
         pin_irq_one <= 1'b0;
         pattern_match_out <= 1'b0;
         cpu_event_notify <= 1'b0;
      end else begin
         irq <= next_irq;
         term_prev <= next_term_prev;
         wake_req <= next_wake;
         pin_irq_zero <= next_dma_zero;
         pin_irq_one <= next_dma_one;
         pattern_match_out <= next_match;
         cpu_event_notify <= next_event;
      end
   end

endmodule // pin_irq_pattern_match

// [test/pin_irq_pattern_match_asserts.sv]
/* checker for the pin interrupt and pattern match engine.
   sees only the top module's ports; bound after the module. */
`timescale 1ns/1ps
module pin_irq_checks (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // configuration and clears
   input wire [7:0] chan_mode,
   input wire [7:0] rise_en,
   input wire [7:0] fall_en,
   input wire [7:0] level_high,
   input wire [7:0] level_en,
   input wire [7:0] clr_rise,
   input wire [7:0] clr_fall,
   input wire [7:0] term_end,
   input wire pattern_en,
   input wire event_en,
   // results
   input wire [7:0] irq,
   input wire [7:0] rise_flag,
   input wire [7:0] fall_flag,
   input wire [7:0] pin_level,
   input wire wake_req,
   input wire pin_irq_zero,
   input wire pin_irq_one,
   input wire pattern_match_out,
   input wire cpu_event_notify
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_edge_irq_cause: assert property (!$past(chan_mode[0]) &&
      !$past(pattern_en) |-> irq[0] == ($past(rise_flag[0] & rise_en[0])
      | $past(fall_flag[0] & fall_en[0]))) else $error("edge irq wrong");
   a_level_irq_pol: assert property ($past(chan_mode[0]) &&
      !$past(pattern_en) |-> irq[0] == ($past(level_en[0]) &&
      pin_level[0] == $past(level_high[0]))) else $error("level irq wrong");
   a_wake_pin_or: assert property (!$past(pattern_en) |-> wake_req == |irq)
      else $error("wake not or of irqs");
   a_wake_pattern_off: assert property ($past(pattern_en) |-> !wake_req)
      else $error("wake in pattern mode");
   a_dma_trig_copy: assert property (!$past(pattern_en) |->
      {pin_irq_one, pin_irq_zero} == irq[1:0]) else $error("dma trig wrong");
   a_match_out_or: assert property
      (pattern_match_out == ($past(pattern_en) && |irq))
      else $error("match out wrong");
   a_event_cause: assert property (cpu_event_notify |->
      $past(event_en) && pattern_match_out) else $error("stray event");
   a_sync_edge_seen: assert property ($rose(rise_flag[0]) |->
      pin_level[0] && !$past(pin_level[0])) else $error("edge timing");
   a_flag_sticky: assert property (rise_flag[0] && !clr_rise[0] |=>
      rise_flag[0]) else $error("flag lost");
   a_fall_sticky: assert property (fall_flag[0] && !clr_fall[0] |=>
      fall_flag[0]) else $error("fall flag lost");
   a_term_lines_only: assert property ($past(pattern_en) |->
      (irq & ~$past(term_end)) == 8'h00) else $error("irq off term");
endmodule // pin_irq_checks

bind pin_irq_pattern_match pin_irq_checks checks (.*);

// [test/irq_sink_model.sv]
/* model of the interrupt controller and event input.
   latches every irq line and counts event pulses on clk. */
`timescale 1ns/1ps
module irq_sink_model (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // requests
   input wire [7:0] irq,
   input wire cpu_event_notify,
   // observed
   output logic [7:0] seen,
   output logic [7:0] ev_count
);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen <= 8'h00;
         ev_count <= 8'h00;
      end else begin
         seen <= seen | irq;
         ev_count <= ev_count + {7'h00, cpu_event_notify};
      end
   end
endmodule // irq_sink_model

// [test/pin_irq_pattern_match_bench.sv]
/* self-checking bench for the pin interrupt and pattern match engine.
   inputs move 1 ns after the rising edge of a 10 ns clock. */
`timescale 1ns/1ps
module pin_irq_pattern_match_bench;
   logic clk, rst_n, pattern_en, event_en, pattern_clr_edges;
   logic [31:0] pins;
   logic [39:0] pin_sel;
   logic [23:0] slice_src, slice_cond;
   logic [7:0] chan_mode, rise_en, fall_en, level_en, level_high;
   logic [7:0] clr_rise, clr_fall, term_end, irq, rise_flag, fall_flag;
   logic [7:0] pin_level, seen, ev_count;
   logic wake_req, pin_irq_zero, pin_irq_one, pattern_match_out;
   logic cpu_event_notify;
   int n_fail, comparisons;
   pin_irq_pattern_match dut (.clk(clk), .rst_n(rst_n), .pins(pins),
      .pin_sel(pin_sel), .chan_mode(chan_mode), .rise_en(rise_en),
      .fall_en(fall_en), .level_en(level_en), .level_high(level_high),
      .clr_rise(clr_rise), .clr_fall(clr_fall), .pattern_en(pattern_en),
      .event_en(event_en), .slice_src(slice_src), .slice_cond(slice_cond),
      .term_end(term_end), .pattern_clr_edges(pattern_clr_edges),
      .irq(irq), .rise_flag(rise_flag), .fall_flag(fall_flag),
      .pin_level(pin_level), .wake_req(wake_req),
      .pin_irq_zero(pin_irq_zero), .pin_irq_one(pin_irq_one),
      .pattern_match_out(pattern_match_out),
      .cpu_event_notify(cpu_event_notify));
   irq_sink_model sink (.clk(clk), .rst_n(rst_n), .irq(irq),
      .cpu_event_notify(cpu_event_notify), .seen(seen),
      .ev_count(ev_count));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // edge channel c on pin p, rising or falling, then cleared
   task t_edge(input int c, input int p, input logic r);
      pin_sel[c*5+:5] = p[4:0];
      rise_en[c] = r;
      fall_en[c] = !r;
      pins[p] = !r;
      step(5);
      pins[p] = r;
      step(4);
      chk(irq, 8'h01 << c);
      chk({pin_irq_one, pin_irq_zero}, 8'h01 << c);
      chk(wake_req, 1);
      chk(r ? rise_flag[c] : fall_flag[c], 1);
      chk(pin_level[c], r);
      clr_rise[c] = r;
      clr_fall[c] = !r;
      step(1);
      clr_rise = 0;
      clr_fall = 0;
      step(1);
      chk(irq, 0);
      chk(r ? rise_flag[c] : fall_flag[c], 0);
      $display("edge test on channel %0d done", c);
   endtask
   task t_level;
      pin_sel[14:10] = 5'h03;
      {chan_mode[2], level_en[2], level_high[2]} = 3'b110;
      pins[3] = 1;
      step(4);
      chk(irq, 0);
      pins[3] = 0;
      step(3);
      chk(irq, 8'h04);
      pins[3] = 1;
      step(3);
      chk(irq, 0);
      level_en[2] = 0;
      $display("level test done");
   endtask
   task t_pattern;
      pins[5] = 0;
      step(4);
      {pattern_en, event_en, term_end} = 10'h301;
      slice_cond[2:0] = 3'h4;
      step(2);
      pins[5] = 1;
      step(3);
      chk(irq, 8'h01);
      chk(pattern_match_out, 1);
      chk(wake_req, 0);
      chk(cpu_event_notify, 1);
      step(2);
      chk(ev_count, 8'h01);
      chk(seen, 8'h07);
      $display("pattern test done");
   endtask
   // two-slice term: channel 0 high and a sticky rise on channel 1
   task t_terms;
      slice_src[5:3] = 3'h1;
      slice_cond[5:3] = 3'h1;
      term_end = 8'h02;
      pattern_clr_edges = 1;
      step(1);
      pattern_clr_edges = 0;
      step(2);
      chk(irq, 0);
      pins[9] = 1;
      step(4);
      chk(irq, 8'h02);
      chk(pattern_match_out, 1);
      pins[5] = 0;
      step(3);
      chk(irq, 0);
      $display("product term test done");
   endtask
   initial begin
      #300000;
      n_fail++;
      close_out;
   end
   initial begin
      {rst_n, pattern_en, event_en, pattern_clr_edges} = 0;
      {pins, pin_sel, slice_src, slice_cond} = 0;
      {chan_mode, rise_en, fall_en, level_en, level_high} = 0;
      {clr_rise, clr_fall, term_end} = 0;
      step(5);
      rst_n = 1;
      step(2);
      chk(irq, 0);
      t_edge(0, 5, 1);
      t_edge(1, 9, 0);
      t_level;
      t_pattern;
      t_terms;
      close_out;
   end
endmodule // pin_irq_pattern_match_bench
